//--- hw/rfac_pkg.sv
// Constants shared by the analog-control register bank and its serial port.
// Assumes the register port carries 6-bit addresses and 8-bit data.
package rfac_pkg;

  // ---------------------------------------------------------------------------
  // Clock figures
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned REF_CLK_HZ = 13000000;
  // Fewest system clocks per serial clock half period that the filter keeps up with.
  localparam int unsigned SCK_MIN_HALF_CYC = 4;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [5:0] RFAC_ADDR_CONTROL = 6'h03;
  localparam logic [5:0] RFAC_ADDR_ANALOG_CTL = 6'h20;
  localparam logic [5:0] RFAC_ADDR_STRENGTH = 6'h22;
  localparam logic [5:0] RFAC_ADDR_TX_POWER = 6'h23;
  localparam logic [5:0] RFAC_ADDR_CRYSTAL = 6'h24;
  localparam logic [5:0] RFAC_ADDR_OSC_SLOPE = 6'h26;
  localparam logic [5:0] RFAC_ADDR_GAIN_LOOP = 6'h2e;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned RFAC_BIT_RX_MODE = 7;
  localparam int unsigned RFAC_BIT_OVR_WR_EN = 6;
  localparam int unsigned RFAC_BIT_SOFT_RST = 0;
  localparam int unsigned RFAC_BIT_VALID = 5;
  localparam int unsigned RFAC_BIT_CLK_DIS = 6;
  localparam int unsigned RFAC_BIT_FREEZE = 7;
  localparam int unsigned RFAC_SLOPE_LSB = 6;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RFAC_RST_BYTE = 8'h00;
  localparam logic [2:0] RFAC_RST_DRIVE = 3'h0;
  localparam logic [5:0] RFAC_RST_TRIM = 6'h00;
  localparam logic [4:0] RFAC_RST_STRENGTH = 5'h00;

  // ---------------------------------------------------------------------------
  // Oscillator slope codes
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RFAC_SLOPE_NONE = 2'h0,
    RFAC_SLOPE_RSVD = 2'h1,
    RFAC_SLOPE_SMALL = 2'h2,
    RFAC_SLOPE_LARGE = 2'h3
  } rfac_slope_t;

endpackage

//--- hw/rfac_reg_if.sv
// Internal register access path between the serial port and the register bank.
// Assumes both ends run on one clock; the write strobe is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none

interface rfac_reg_if;
  logic wr_stb;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport port (output wr_stb, output addr, output wdata, input rdata);
  modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

//--- hw/rfac_regs.sv
// Analog front-end control register bank with its serial register port.
// Assumes strength inputs come from logic on clk_in; serial pins are asynchronous.
//
// How it works
// - One strength capture per entry into receive.
// - Bit 5 flags the stored sample valid.
// - Strength is 5-bit, bigger means stronger.
// - Strength register read-only; bits 7:6 reserved.
// - Three-bit amplifier drive, higher code, more power.
// - Crystal bit 6 stops reference clock output.
// - Six-bit trim sets crystal load capacitance.
// - Slope codes 11, 10, 00 decode to adjustments.
// - Slope field is write-only; reads undefined.
// - Freeze bit disables gain loop, max gain.
// - Gain register writable only when unlocked.
// - Analog control bit 6 unlocks gain overrides.
// - Self-clearing reset bit restores bank defaults.
`timescale 1ns/1ps
`default_nettype none

module rfac_regs
  import rfac_pkg::*;
(
  input wire logic clk_in,                   // System clock, 125 MHz.
  input wire logic rst_in,                   // Synchronous reset, active high.
  input wire logic spi_sck_in,               // Serial clock pin.
  input wire logic spi_mosi_in,              // Serial data in pin.
  input wire logic spi_ssn_in,               // Select pin, active low.
  output logic spi_miso_out,                 // Serial data out.
  output logic spi_miso_oe_out,              // High while serial data out is driven.
  input wire logic [4:0] signal_strength_value_in, // Live strength measurement.
  input wire logic strength_ok_in,           // Live measurement is trustworthy.
  output logic rx_mode_out,                  // Receive mode selected.
  output logic [2:0] amp_drive_level_out,    // Transmit amplifier drive code.
  output logic ref_clock_out_pin_en_out,     // Enable for the reference clock pin.
  output logic [5:0] crystal_trim_out,       // Crystal load capacitance trim.
  output logic [1:0] osc_slope_select_out,   // Raw oscillator slope code.
  output logic [2:0] osc_adj_minus_out,      // Downward slope adjustment.
  output logic [2:0] osc_adj_plus_out,       // Upward slope adjustment.
  output logic gain_loop_freeze_out,         // Automatic gain loop disabled.
  output logic lna_unused_pwrdn_out,         // Power down idle gain loop circuits.
  output logic lna_max_gain_out,             // Hold low-noise amplifier at max gain.
  output logic gain_override_write_enable_out // Gain override registers unlocked.
);

  // ---------------------------------------------------------------------------
  // Serial port
  // ---------------------------------------------------------------------------
  rfac_reg_if reg_bus ();

  rfac_spi_port u_spi (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .spi_sck_in(spi_sck_in),
    .spi_mosi_in(spi_mosi_in),
    .spi_ssn_in(spi_ssn_in),
    .spi_miso_out(spi_miso_out),
    .spi_miso_oe_out(spi_miso_oe_out),
    .reg_bus(reg_bus.port)
  );

  // ---------------------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------------------
  function automatic logic wr_hit(input logic stb, input logic [5:0] a, input logic [5:0] o);
    wr_hit = stb && (a == o);
  endfunction

  logic soft_rst;
  logic bank_clr;
  assign soft_rst = wr_hit(reg_bus.wr_stb, reg_bus.addr, RFAC_ADDR_ANALOG_CTL)
                    && reg_bus.wdata[RFAC_BIT_SOFT_RST];
  // The reset bit is never stored, so it reads back as zero: self-clearing.
  assign bank_clr = rst_in || soft_rst;

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  logic rx_mode_r;
  logic ovr_wr_en_r;
  logic [2:0] drive_r;
  logic clk_dis_r;
  logic [5:0] trim_r;
  logic [1:0] slope_r;
  logic freeze_r;
  logic rx_enter;
  assign rx_enter = wr_hit(reg_bus.wr_stb, reg_bus.addr, RFAC_ADDR_CONTROL)
                    && reg_bus.wdata[RFAC_BIT_RX_MODE] && !rx_mode_r;

  // Receive mode and the override unlock.
  always_ff @(posedge clk_in) begin
    if (bank_clr) begin
      rx_mode_r <= 1'b0;
      ovr_wr_en_r <= 1'b0;
    end else if (reg_bus.wr_stb) begin
      if (reg_bus.addr == RFAC_ADDR_CONTROL) begin
        rx_mode_r <= reg_bus.wdata[RFAC_BIT_RX_MODE];
      end
      if (reg_bus.addr == RFAC_ADDR_ANALOG_CTL) begin
        ovr_wr_en_r <= reg_bus.wdata[RFAC_BIT_OVR_WR_EN];
      end
    end
  end

  // Front-end settings; reserved bits are dropped so they read as zero.
  always_ff @(posedge clk_in) begin
    if (bank_clr) begin
      drive_r <= RFAC_RST_DRIVE;
      clk_dis_r <= 1'b0;
      trim_r <= RFAC_RST_TRIM;
      slope_r <= RFAC_SLOPE_NONE;
    end else if (reg_bus.wr_stb) begin
      unique case (reg_bus.addr)
        RFAC_ADDR_TX_POWER: begin
          drive_r <= reg_bus.wdata[2:0];
        end
        RFAC_ADDR_CRYSTAL: begin
          clk_dis_r <= reg_bus.wdata[RFAC_BIT_CLK_DIS];
          trim_r <= reg_bus.wdata[5:0];
        end
        RFAC_ADDR_OSC_SLOPE: begin
          slope_r <= reg_bus.wdata[RFAC_SLOPE_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
  end

  // The lock bit only takes a write while the override unlock is set.
  always_ff @(posedge clk_in) begin
    if (bank_clr) begin
      freeze_r <= 1'b0;
    end else if (wr_hit(reg_bus.wr_stb, reg_bus.addr, RFAC_ADDR_GAIN_LOOP)
                 && ovr_wr_en_r) begin
      freeze_r <= reg_bus.wdata[RFAC_BIT_FREEZE];
    end
  end

  // ---------------------------------------------------------------------------
  // Strength capture
  // ---------------------------------------------------------------------------
  logic [4:0] strength_r;
  logic valid_r;

  // Capture happens only on the write that enters receive; re-writing the bit
  // while already receiving takes no new sample. Writes at the strength offset
  // have no path here at all.
  always_ff @(posedge clk_in) begin
    if (bank_clr) begin
      strength_r <= RFAC_RST_STRENGTH;
      valid_r <= 1'b0;
    end else if (rx_enter) begin
      strength_r <= signal_strength_value_in;
      valid_r <= strength_ok_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  // The slope register returns zero; its read value is not meant to be used.
  always_comb begin
    unique case (reg_bus.addr)
      RFAC_ADDR_CONTROL: reg_bus.rdata = {rx_mode_r, 7'h00};
      RFAC_ADDR_ANALOG_CTL: reg_bus.rdata = {1'b0, ovr_wr_en_r, 6'h00};
      RFAC_ADDR_STRENGTH: reg_bus.rdata = {2'h0, valid_r, strength_r};
      RFAC_ADDR_TX_POWER: reg_bus.rdata = {5'h00, drive_r};
      RFAC_ADDR_CRYSTAL: reg_bus.rdata = {1'b0, clk_dis_r, trim_r};
      RFAC_ADDR_OSC_SLOPE: reg_bus.rdata = RFAC_RST_BYTE;
      RFAC_ADDR_GAIN_LOOP: reg_bus.rdata = {freeze_r, 7'h00};
      default: reg_bus.rdata = RFAC_RST_BYTE;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Slope decode
  // ---------------------------------------------------------------------------
  // The reserved code is treated as no adjustment, the safest choice.
  function automatic logic [5:0] slope_adj(input logic [1:0] code);
    unique case (code)
      RFAC_SLOPE_LARGE: slope_adj = {3'h5, 3'h5};
      RFAC_SLOPE_SMALL: slope_adj = {3'h2, 3'h3};
      RFAC_SLOPE_RSVD: slope_adj = 6'h00;
      RFAC_SLOPE_NONE: slope_adj = 6'h00;
    endcase
  endfunction

  logic [2:0] adj_minus_r;
  logic [2:0] adj_plus_r;
  always_ff @(posedge clk_in) begin
    if (bank_clr) begin
      adj_minus_r <= 3'h0;
      adj_plus_r <= 3'h0;
    end else begin
      {adj_minus_r, adj_plus_r} <= slope_adj(slope_r);
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign rx_mode_out = rx_mode_r;
  assign amp_drive_level_out = drive_r;
  assign ref_clock_out_pin_en_out = !clk_dis_r;
  assign crystal_trim_out = trim_r;
  assign osc_slope_select_out = slope_r;
  assign osc_adj_minus_out = adj_minus_r;
  assign osc_adj_plus_out = adj_plus_r;
  // One lock bit drives all three effects together.
  assign gain_loop_freeze_out = freeze_r;
  assign lna_unused_pwrdn_out = freeze_r;
  assign lna_max_gain_out = freeze_r;
  assign gain_override_write_enable_out = ovr_wr_en_r;

endmodule

`default_nettype wire

//--- hw/rfac_spi_port.sv
// Serial register port: synchronises the pins and turns frames into accesses.
// Assumes mode 0 framing: command byte {write, x, addr[5:0]}, then data bytes.
`timescale 1ns/1ps
`default_nettype none

module rfac_spi_port
  import rfac_pkg::*;
(
  input wire logic clk_in,        // System clock.
  input wire logic rst_in,        // Synchronous reset, active high.
  input wire logic spi_sck_in,    // Serial clock pin.
  input wire logic spi_mosi_in,   // Serial data in pin.
  input wire logic spi_ssn_in,    // Select pin, active low.
  output logic spi_miso_out,      // Serial data out.
  output logic spi_miso_oe_out,   // Drive enable for serial data out.
  rfac_reg_if.port reg_bus        // Access path to the bank.
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Pin order is {ssn, sck, mosi}; only stages two and three feed the filter.
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] pin_r;
  logic [2:0] pin_nxt;

  always_comb begin
    pin_nxt = (sync2_r & ~(sync2_r ^ sync3_r)) | (pin_r & (sync2_r ^ sync3_r));
  end

  // A level only changes once two stages agree, which rejects single-cycle glitches.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_r <= 3'h4;
      sync2_r <= 3'h4;
      sync3_r <= 3'h4;
      pin_r <= 3'h4;
    end else begin
      sync1_r <= {spi_ssn_in, spi_sck_in, spi_mosi_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_r <= pin_nxt;
    end
  end

  logic selected;
  logic sck_rise;
  logic sck_fall;
  assign selected = ~pin_nxt[2];
  assign sck_rise = selected & pin_nxt[1] & ~pin_r[1];
  assign sck_fall = selected & ~pin_nxt[1] & pin_r[1];

  // ---------------------------------------------------------------------------
  // Frame decoding
  // ---------------------------------------------------------------------------
  logic [2:0] bit_cnt_r;
  logic cmd_done_r;
  logic is_wr_r;
  logic [5:0] addr_r;
  logic [7:0] rx_r;
  logic wr_stb_r;
  logic [7:0] wdata_r;
  logic [7:0] rx_byte;
  assign rx_byte = {rx_r[6:0], pin_nxt[0]};

  // Bytes after the command all go to the same address.
  always_ff @(posedge clk_in) begin
    if (rst_in || !selected) begin
      bit_cnt_r <= 3'h0;
      cmd_done_r <= 1'b0;
      is_wr_r <= 1'b0;
      addr_r <= 6'h00;
      rx_r <= RFAC_RST_BYTE;
      wr_stb_r <= 1'b0;
      wdata_r <= RFAC_RST_BYTE;
    end else begin
      wr_stb_r <= 1'b0;
      if (sck_rise) begin
        rx_r <= rx_byte;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7) begin
          if (!cmd_done_r) begin
            cmd_done_r <= 1'b1;
            is_wr_r <= rx_byte[7];
            addr_r <= rx_byte[5:0];
          end else if (is_wr_r) begin
            wr_stb_r <= 1'b1;
            wdata_r <= rx_byte;
          end
        end
      end
    end
  end

  assign reg_bus.wr_stb = wr_stb_r;
  assign reg_bus.addr = addr_r;
  assign reg_bus.wdata = wdata_r;

  // ---------------------------------------------------------------------------
  // Read data shifter
  // ---------------------------------------------------------------------------
  // Loading on the falling edge at a byte boundary puts bit 7 out before the
  // host samples it, and refreshes the value for repeated reads.
  logic [7:0] tx_r;
  always_ff @(posedge clk_in) begin
    if (rst_in || !selected) begin
      tx_r <= RFAC_RST_BYTE;
    end else if (sck_fall) begin
      if (bit_cnt_r == 3'h0) begin
        tx_r <= (cmd_done_r && !is_wr_r) ? reg_bus.rdata : RFAC_RST_BYTE;
      end else begin
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      spi_miso_out <= 1'b0;
      spi_miso_oe_out <= 1'b0;
    end else begin
      spi_miso_out <= tx_r[7];
      spi_miso_oe_out <= selected;
    end
  end

endmodule

`default_nettype wire

//--- verification/rfac_host_model.sv
// Host microcontroller model: mode 0 serial master with two-byte frames, a command byte then one data byte.
// Assumes the caller starts a frame just after a rising edge of clk_in.
`timescale 1ns/1ps
`default_nettype none
module rfac_host_model (
  input wire logic clk_in,     // Paces the serial clock.
  input wire logic miso_in,    // Device serial data.
  input wire logic miso_oe_in, // Device drive enable.
  output logic sck_out,        // Serial clock, idle low.
  output logic mosi_out,       // Serial data to the device.
  output logic ssn_out         // Select, active low.
);
  logic flip_r = 1'b0;
  wire logic line_w;
  // An undriven line toggles so a stale bit never passes for good data.
  always @(posedge clk_in) begin
    flip_r <= ~flip_r;
  end
  assign line_w = miso_oe_in ? miso_in : flip_r;
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b0;
    ssn_out = 1'b1;
  end
  // Half periods of 8 clocks leave the pin filter twice the margin it needs.
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    ssn_out <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_out <= sh[i];
      repeat (8) @(posedge clk_in);
      if (i < 8) rd[i] = line_w;
      sck_out <= 1'b1;
      repeat (8) @(posedge clk_in);
      sck_out <= 1'b0;
    end
    repeat (8) @(posedge clk_in);
    ssn_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

//--- verification/rfac_regs_checker.sv
// Concurrent checks on the pins of the analog-control register bank.
// Assumes every watched signal lives on clk_in with a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module rfac_regs_checker (
  input wire logic clk_in,                        // System clock.
  input wire logic rst_in,                        // Synchronous reset.
  input wire logic rx_mode_out,                   // Receive mode.
  input wire logic [2:0] amp_drive_level_out,     // Drive code.
  input wire logic ref_clock_out_pin_en_out,      // Clock pin enable.
  input wire logic [5:0] crystal_trim_out,        // Load trim.
  input wire logic [1:0] osc_slope_select_out,    // Slope code.
  input wire logic [2:0] osc_adj_minus_out,       // Down adjust.
  input wire logic [2:0] osc_adj_plus_out,        // Up adjust.
  input wire logic gain_loop_freeze_out,          // Gain loop frozen.
  input wire logic lna_unused_pwrdn_out,          // Idle power down.
  input wire logic lna_max_gain_out,              // Max gain hold.
  input wire logic gain_override_write_enable_out // Override unlock.
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ---------------------------------------------------------------------------
  // Reset values; these two must see the reset itself, so they are never disabled.
  // ---------------------------------------------------------------------------
  property p_rst_clk_en;
    disable iff (1'b0) rst_in |=> ref_clock_out_pin_en_out;
  endproperty
  a_rst_clk_en: assert property (p_rst_clk_en) else $error("clock pin off after reset");
  property p_rst_dflt;
    disable iff (1'b0) rst_in |=> amp_drive_level_out == 3'h0 && crystal_trim_out == 6'h00
      && !rx_mode_out && !gain_loop_freeze_out && !gain_override_write_enable_out;
  endproperty
  a_rst_dflt: assert property (p_rst_dflt) else $error("register not at default");
  // ---------------------------------------------------------------------------
  // Gain loop and slope decode.
  // ---------------------------------------------------------------------------
  property p_freeze_pair;
    gain_loop_freeze_out == lna_max_gain_out && gain_loop_freeze_out == lna_unused_pwrdn_out;
  endproperty
  a_freeze_pair: assert property (p_freeze_pair) else $error("freeze outputs disagree");
  property p_freeze_gate;
    $rose(gain_loop_freeze_out) |-> $past(gain_override_write_enable_out);
  endproperty
  a_freeze_gate: assert property (p_freeze_gate) else $error("gain written while locked");
  // The decode is registered a cycle behind the code, so the code must hold a cycle.
  property p_slope_large;
    osc_slope_select_out == 2'h3 ##1 osc_slope_select_out == 2'h3
      |-> osc_adj_minus_out == 3'h5 && osc_adj_plus_out == 3'h5;
  endproperty
  a_slope_large: assert property (p_slope_large) else $error("slope 11 decode wrong");
  property p_slope_small;
    osc_slope_select_out == 2'h2 ##1 osc_slope_select_out == 2'h2
      |-> osc_adj_minus_out == 3'h2 && osc_adj_plus_out == 3'h3;
  endproperty
  a_slope_small: assert property (p_slope_small) else $error("slope 10 decode wrong");
  property p_slope_none;
    osc_slope_select_out[1] == 1'b0 |=> osc_adj_minus_out == 3'h0 && osc_adj_plus_out == 3'h0;
  endproperty
  a_slope_none: assert property (p_slope_none) else $error("slope 0x decode wrong");
  // One host write touches one register, so two changing at once means a bank clear.
  property p_soft_clear;
    $changed(amp_drive_level_out) && $changed(crystal_trim_out) |-> amp_drive_level_out == 3'h0
      && crystal_trim_out == 6'h00 && ref_clock_out_pin_en_out && !gain_override_write_enable_out;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft clear incomplete");
endmodule
bind rfac_regs rfac_regs_checker u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .rx_mode_out(rx_mode_out), .amp_drive_level_out(amp_drive_level_out),
  .ref_clock_out_pin_en_out(ref_clock_out_pin_en_out), .crystal_trim_out(crystal_trim_out),
  .osc_slope_select_out(osc_slope_select_out), .osc_adj_minus_out(osc_adj_minus_out),
  .osc_adj_plus_out(osc_adj_plus_out), .gain_loop_freeze_out(gain_loop_freeze_out),
  .lna_unused_pwrdn_out(lna_unused_pwrdn_out), .lna_max_gain_out(lna_max_gain_out),
  .gain_override_write_enable_out(gain_override_write_enable_out));
`default_nettype wire

//--- verification/rfac_regs_tb.sv
// Self-checking bench for the register bank, compared against a behavioural model.
// Assumes the host model and checker files are compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module rfac_regs_tb;
  import rfac_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] str_r = 5'h00;
  logic ok_r = 1'b0;
  wire logic sck, mosi, ssn, miso, oe, rx, ref_en, frz, pwd, mxg, unl;
  wire logic [2:0] amp, mns, pls;
  wire logic [5:0] trim;
  wire logic [1:0] slope;
  wire logic [22:0] got_w;
  int error_cnt = 0;
  int num_checks = 0;
  int mdl [int];
  logic [7:0] map_q [$] = '{8'h03, 8'h20, 8'h22, 8'h23, 8'h24, 8'h2e, 8'h3f};
  always #4 clk_in = ~clk_in;
  assign got_w = {rx, amp, ref_en, trim, slope, mns, pls, frz, pwd, mxg, unl};
  rfac_regs DUT (.clk_in(clk_in), .rst_in(rst_in), .spi_sck_in(sck), .spi_mosi_in(mosi),
    .spi_ssn_in(ssn), .spi_miso_out(miso), .spi_miso_oe_out(oe),
    .signal_strength_value_in(str_r), .strength_ok_in(ok_r), .rx_mode_out(rx),
    .amp_drive_level_out(amp), .ref_clock_out_pin_en_out(ref_en), .crystal_trim_out(trim),
    .osc_slope_select_out(slope), .osc_adj_minus_out(mns), .osc_adj_plus_out(pls),
    .gain_loop_freeze_out(frz), .lna_unused_pwrdn_out(pwd), .lna_max_gain_out(mxg),
    .gain_override_write_enable_out(unl));
  rfac_host_model u_host (.clk_in(clk_in), .miso_in(miso), .miso_oe_in(oe), .sck_out(sck),
    .mosi_out(mosi), .ssn_out(ssn));
  // ---------------------------------------------------------------------------
  // Reference model and comparisons.
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [22:0] got, input logic [22:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t pins %h expected %h", $time, got, exp);
    end
  endtask
  // The slope register is cleared too, though it is never read back.
  function automatic void mdl_clr();
    foreach (map_q[i]) mdl[map_q[i]] = 0;
    mdl[8'h26] = 0;
  endfunction
  // Slope decode is written out here, not taken from the package, to stay independent.
  function automatic logic [22:0] exp_out();
    logic [1:0] s;
    logic [2:0] m;
    logic [2:0] p;
    s = mdl[8'h26][7:6];
    m = (s == 2'h3) ? 3'h5 : (s == 2'h2) ? 3'h2 : 3'h0;
    p = (s == 2'h3) ? 3'h5 : (s == 2'h2) ? 3'h3 : 3'h0;
    return {mdl[8'h03][7], mdl[8'h23][2:0], ~mdl[8'h24][6], mdl[8'h24][5:0], s, m, p,
      {3{mdl[8'h2e][7]}}, mdl[8'h20][6]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_host.xfer({2'h2, a[5:0]}, d, r);
    case (a)
      8'h03: begin
        if (d[7] && !mdl[8'h03][7]) mdl[8'h22] = {2'h0, ok_r, str_r};
        mdl[8'h03] = d & 8'h80;
      end
      8'h20: if (d[0]) mdl_clr(); else mdl[8'h20] = d & 8'h40;
      8'h23: mdl[8'h23] = d & 8'h07;
      8'h24: mdl[8'h24] = d & 8'h7f;
      8'h26: mdl[8'h26] = d & 8'hc0;
      8'h2e: if (mdl[8'h20][6]) mdl[8'h2e] = d & 8'h80;
      default: ;
    endcase
    chk_out(got_w, exp_out());
  endtask
  // The slope register is never read back: its read value is undefined.
  task automatic rd(input logic [7:0] a);
    logic [7:0] r;
    u_host.xfer({2'h0, a[5:0]}, 8'h00, r);
    chk_rd(r, mdl.exists(a) ? mdl[a][7:0] : 8'h00);
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence and watchdog.
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(93));
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    mdl_clr();
    repeat (4) @(posedge clk_in);
    chk_out(got_w, exp_out());
    foreach (map_q[i]) rd(map_q[i]);
    for (int i = 0; i < 4; i++) wr(8'h26, {i[1:0], 6'h00});
    wr(8'h2e, 8'h80);
    rd(8'h2e);
    wr(8'h20, 8'h40);
    wr(8'h2e, 8'h80);
    rd(8'h2e);
    repeat (3) begin
      wr(8'h23, {5'h00, 3'($urandom)});
      rd(8'h23);
    end
    wr(8'h23, 8'h07);
    wr(8'h24, {2'h1, 6'($urandom)});
    rd(8'h24);
    wr(8'h24, 8'h7f);
    for (int i = 0; i < 3; i++) begin
      str_r <= 5'($urandom);
      ok_r <= i[0];
      wr(8'h03, 8'h80);
      rd(8'h22);
      str_r <= ~str_r;
      wr(8'h03, 8'h80);
      wr(8'h22, 8'hff);
      rd(8'h22);
      wr(8'h03, 8'h00);
      rd(8'h03);
    end
    wr(8'h20, 8'h01);
    foreach (map_q[i]) rd(map_q[i]);
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
